// file: hdl/ict_channel.sv
// Purpose: One input capture channel with dedicated 16-bit counter
// Assumes: Pin input asynchronous; tick and source inputs on clk_i
// Notes:   Cascade partner wires connect two channel instances
`timescale 1ns/1ps
`default_nettype none

// Function
// - Counter counts up continuously on chosen clock, wraps from ffff to 0000.
// - Each capture event with the FIFO not full pushes the present counter value into it.
// - Sync mode runs once clock enabled; sync source events clear counter.
// - Trigger mode holds counter stopped until a source event, then runs.
// - Trigger status set by hardware or software; while clear counter held zero.
// - Source zero and trigger select clear is free running; else sync or trigger.
// - Source zero with trigger select set is software trigger mode.
// - Odd channel gives low half; odd rollover increments the even counter.
// - Cascade only when both channels set cascade enable; else 16-bit.
// - Even channel in cascade runs synchronised to the odd channel.
// - Cascaded sync: both channels held in reset until source enabled.
// - Software programs both channels identically, even channel first.
// - Capture on rising edges, every transition, every 4th or 16th rise.
// - Interrupt after every capture for 00, every second capture for 01.
// - Clock select: 111 system, 100 t1, 011 t5, 010 t4, 001 t2.
// - Four-entry FIFO; read-only not-empty flag shows data waiting.
// - Not-empty clears by hardware once all values are read.
// - Read-only overflow flag shows a capture overflow happened.
// - Mode 110 disables the channel; no captures.
// - Source select codes pick compare, timer or other sources.
module ict_channel
    import ict_pkg::*;
#(
    parameter int DEPTH = 4
)(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire ict_bus_s    bus_i,
    output logic [15:0]      rdata_o,
    input  wire logic        pin_i,
    input  wire logic [31:0] src_evt_i,
    input  wire logic [31:0] src_en_i,
    input  wire logic [4:0]  tmr_tick_i,
    input  wire logic        casc_in_en_i,
    input  wire logic        casc_in_carry_i,
    input  wire logic        casc_is_even_i,
    output logic             casc_out_en_o,
    output logic             casc_out_carry_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (DEPTH != 4) begin : g_bad_depth
        $error("ict_channel: DEPTH must be 4");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] ctrl1_r;
    logic [15:0] ctrl2_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        trg_r;
    logic        ovf_r;
    logic [15:0] fifo_r [DEPTH];
    logic [1:0]  wp_r;
    logic [1:0]  rp_r;
    logic [2:0]  fill_r;
    logic [3:0]  pre_r;
    logic        cpi_r;
    logic [2:0]  pin_sync_r;
    logic        pin_last_r;

    // Field decode
    wire logic [2:0] clk_sel  = ctrl1_r[ICT_C1_CLKSEL_LSB +: 3];
    wire logic [1:0] cpi_sel  = ctrl1_r[ICT_C1_CPI_LSB +: 2];
    wire logic [2:0] mode     = ctrl1_r[ICT_C1_MODE_LSB +: 3];
    wire logic       casc_own = ctrl2_r[ICT_C2_CASC_BIT];
    wire logic       trg_sel  = ctrl2_r[ICT_C2_TRGSEL_BIT];
    wire logic [4:0] src_sel  = ctrl2_r[ICT_C2_SRC_LSB +: 5];

    // ------------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------------
    wire logic     casc     = casc_own && casc_in_en_i;
    wire logic     even_c   = casc && casc_is_even_i;
    wire ict_run_e run_mode =
        (src_sel == ICT_SRC_NONE) ? (trg_sel ? ICT_SWTRIG : ICT_FREE)
                                  : ((trg_sel && !even_c) ? ICT_HWTRIG
                                                          : ICT_SYNC);
    wire logic src_evt = src_evt_i[src_sel];
    wire logic src_en  = src_en_i[src_sel];

    // Clock select; reserved codes give no ticks
    function automatic logic tick_of(input logic [2:0] sel, input logic [4:0] t);
        unique case (sel)
            ICT_CLK_SYS: tick_of = t[0];
            ICT_CLK_T1:  tick_of = t[1];
            ICT_CLK_T2:  tick_of = t[2];
            ICT_CLK_T4:  tick_of = t[3];
            ICT_CLK_T5:  tick_of = t[4];
            default:     tick_of = 1'b0;
        endcase
    endfunction
    wire logic tick = tick_of(clk_sel, tmr_tick_i);

    // Even channel follows odd carry instead of own tick
    wire logic step = even_c ? casc_in_carry_i : tick;

    // Cascaded sync holds both halves clear until the source runs
    wire logic hold_rst = casc && run_mode == ICT_SYNC && !src_en;
    wire logic trig_hw  = run_mode == ICT_HWTRIG && src_evt;
    wire logic gated    = (run_mode == ICT_HWTRIG || run_mode == ICT_SWTRIG) && !trg_r;
    wire logic sync_clr = run_mode == ICT_SYNC && src_evt;
    wire logic active   = mode != ICT_MODE_OFF && mode != ICT_MODE_DIS;

    // Counter next value
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (hold_rst || gated || sync_clr)
            cnt_nxt = 16'h0000;
        else if (step)
            cnt_nxt = cnt_r + 16'h0001;
    end

    // ------------------------------------------------------------------
    // Edge detect and prescale
    // ------------------------------------------------------------------
    // Change accepted only when last two stages agree
    wire logic pin_stable = pin_sync_r[1] == pin_sync_r[2];
    wire logic pin_now    = pin_stable ? pin_sync_r[2] : pin_last_r;
    wire logic rise       = pin_now && !pin_last_r;
    wire logic any_edge   = pin_now != pin_last_r;
    wire logic [3:0] pre_last = (mode == ICT_MODE_R4) ? ICT_PRE4_LAST : ICT_PRE16_LAST;
    wire logic pre_mode   = mode == ICT_MODE_R4 || mode == ICT_MODE_R16;
    wire logic cap_armed  = active && !hold_rst && !gated;
    wire logic cap_evt    = cap_armed &&
        ((mode == ICT_MODE_BOTH && any_edge) ||
         (mode == ICT_MODE_RISE && rise) ||
         (pre_mode && rise && pre_r == pre_last));

    // ------------------------------------------------------------------
    // FIFO control
    // ------------------------------------------------------------------
    wire logic fifo_rd = bus_i.rd && bus_i.addr == ICT_ADDR_FIFO && fill_r != 3'h0;
    wire logic full    = fill_r == 3'(DEPTH);
    wire logic push    = cap_evt && !full;
    wire logic irq_evt = cap_evt && (cpi_sel == ICT_CPI_EVERY || cpi_r);

    wire logic [15:0] status = {11'h000, ovf_r, fill_r != 3'h0, fill_r};
    wire logic [15:0] ctrl1_rd = {ctrl1_r[15:5], ovf_r, fill_r != 3'h0, ctrl1_r[2:0]};
    wire logic [15:0] ctrl2_rd = {7'h00, ctrl2_r[8:7], trg_r, 1'b0, ctrl2_r[4:0]};
    wire logic [15:0] fifo_rd_val = (fill_r != 3'h0) ? fifo_r[rp_r] : 16'h0000;

    // Read mux; unmapped addresses read as zero
    wire logic [15:0] rd_mux =
        (bus_i.addr == ICT_ADDR_CTRL1)   ? ctrl1_rd :
        (bus_i.addr == ICT_ADDR_CTRL2)   ? ctrl2_rd :
        (bus_i.addr == ICT_ADDR_FIFO)    ? fifo_rd_val :
        (bus_i.addr == ICT_ADDR_COUNTER) ? cnt_r :
        (bus_i.addr == ICT_ADDR_STATUS)  ? status : 16'h0000;

    // ------------------------------------------------------------------
    // Register writes and trigger status
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            ctrl1_r <= ICT_CTRL1_RST;
            ctrl2_r <= ICT_CTRL2_RST;
            trg_r   <= 1'b0;
        end
        else
        begin
            if (bus_i.wr && bus_i.addr == ICT_ADDR_CTRL1)
                ctrl1_r <= bus_i.wdata;
            if (bus_i.wr && bus_i.addr == ICT_ADDR_CTRL2)
                ctrl2_r <= bus_i.wdata;
            // Hardware set wins over a software clear in the same cycle
            if (trig_hw)
                trg_r <= 1'b1;
            else if (bus_i.wr && bus_i.addr == ICT_ADDR_CTRL2)
                trg_r <= bus_i.wdata[ICT_C2_TRGST_BIT];
        end
    end

    // Counter and pin pipeline
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            cnt_r      <= 16'h0000;
            pin_sync_r <= 3'h0;
            pin_last_r <= 1'b0;
            pre_r      <= 4'h0;
        end
        else
        begin
            cnt_r      <= cnt_nxt;
            pin_sync_r <= {pin_sync_r[1:0], pin_i};
            pin_last_r <= pin_now;
            if (!pre_mode)
                pre_r <= 4'h0;
            else if (rise && cap_armed)
                pre_r <= (pre_r == pre_last) ? 4'h0 : pre_r + 4'h1;
        end
    end

    // FIFO storage; data words need no reset
    always_ff @(posedge clk_i)
    begin
        if (push)
            fifo_r[wp_r] <= cnt_r;
    end

    // FIFO pointers, overflow, interrupt divider
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            wp_r   <= 2'h0;
            rp_r   <= 2'h0;
            fill_r <= 3'h0;
            ovf_r  <= 1'b0;
            cpi_r  <= 1'b0;
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 2'h1;
            if (fifo_rd)
                rp_r <= rp_r + 2'h1;
            fill_r <= fill_r + {2'h0, push} - {2'h0, fifo_rd};
            // Overflow held until drained; a new one wins over the clear
            if (cap_evt && full)
                ovf_r <= 1'b1;
            else if (fill_r == 3'h1 && fifo_rd && !push)
                ovf_r <= 1'b0;
            if (!active || cpi_sel == ICT_CPI_EVERY)
                cpi_r <= 1'b0;
            else if (cap_evt)
                cpi_r <= !cpi_r;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rdata_o          <= 16'h0000;
            irq_o            <= 1'b0;
            casc_out_en_o    <= 1'b0;
            casc_out_carry_o <= 1'b0;
        end
        else
        begin
            rdata_o          <= bus_i.rd ? rd_mux : 16'h0000;
            irq_o            <= irq_evt;
            casc_out_en_o    <= casc_own;
            // Carry one cycle late; even half lags by a cycle
            casc_out_carry_o <= step && !hold_rst && !gated && !sync_clr
                                && cnt_r == ICT_CNT_MAX;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Counter
    a_cnt_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cnt_r == ICT_CNT_MAX && step && !hold_rst && !gated && !sync_clr)
        |=> cnt_r == 16'h0000) else $error("counter did not wrap");

    a_cnt_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (step && !hold_rst && !gated && !sync_clr) |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter did not step");

    a_sync_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        sync_clr |=> cnt_r == 16'h0000)
        else $error("sync did not clear");

    a_hold_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        hold_rst |=> cnt_r == 16'h0000)
        else $error("cascade hold let counter run");

    a_gate_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        gated |=> cnt_r == 16'h0000)
        else $error("gated counter ran");

    // Trigger status
    a_trig_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        trig_hw |=> trg_r)
        else $error("trigger status not set");

    a_trig_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (trg_r && !(bus_i.wr && bus_i.addr == ICT_ADDR_CTRL2)) |=> trg_r)
        else $error("trigger status lost");

    a_sw_trig: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (run_mode == ICT_SWTRIG && !trg_r) |-> !push)
        else $error("capture before software trigger");

    // Cascade carry
    a_carry_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cnt_r == ICT_CNT_MAX && step && !hold_rst && !gated && !sync_clr)
        |=> casc_out_carry_o)
        else $error("no carry on wrap");

    // Capture and FIFO
    a_cap_value: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (push && fill_r == 3'h0 && !fifo_rd) |=> fifo_r[rp_r] == $past(cnt_r))
        else $error("captured value wrong");

    a_mode_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        mode == ICT_MODE_DIS |-> !push)
        else $error("capture while disabled");

    a_ne_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (fill_r == 3'h1 && fifo_rd && !push) |=> status[ICT_C1_NE_BIT] == 1'b0)
        else $error("not empty stuck");

    a_ovf_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cap_evt && full) |=> ovf_r && fill_r == 3'(DEPTH))
        else $error("overflow lost");

    a_ovf_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ovf_r && fill_r > 3'h1) |=> ovf_r)
        else $error("overflow cleared early");

    a_fill_max: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        fill_r <= 3'(DEPTH))
        else $error("fifo overfilled");

    // Interrupt divider
    a_irq_every: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cap_evt && cpi_sel == ICT_CPI_EVERY) |=> irq_o)
        else $error("irq missing");

    a_irq_two: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cap_evt && cpi_sel == ICT_CPI_TWO && !cpi_r) |=> !irq_o)
        else $error("irq on odd capture");

endmodule

`default_nettype wire

// file: inc/ict_pkg.sv
// Purpose: Shared constants and types for the input capture channel
// Assumes: 16-bit register port, one 40 MHz clock
// Notes:   Register offsets are word indices on the plain register port
package ict_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [2:0] ICT_ADDR_CTRL1   = 3'h0;
    localparam logic [2:0] ICT_ADDR_CTRL2   = 3'h1;
    localparam logic [2:0] ICT_ADDR_FIFO    = 3'h2;
    localparam logic [2:0] ICT_ADDR_COUNTER = 3'h3;
    localparam logic [2:0] ICT_ADDR_STATUS  = 3'h4;

    // ------------------------------------------------------------------
    // Control 1 field positions
    // ------------------------------------------------------------------
    localparam int ICT_C1_CLKSEL_LSB = 10;
    localparam int ICT_C1_CPI_LSB    = 5;
    localparam int ICT_C1_OVF_BIT    = 4;
    localparam int ICT_C1_NE_BIT     = 3;
    localparam int ICT_C1_MODE_LSB   = 0;

    // ------------------------------------------------------------------
    // Control 2 field positions
    // ------------------------------------------------------------------
    localparam int ICT_C2_CASC_BIT   = 8;
    localparam int ICT_C2_TRGSEL_BIT = 7;
    localparam int ICT_C2_TRGST_BIT  = 6;
    localparam int ICT_C2_SRC_LSB    = 0;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] ICT_CTRL1_RST = 16'h0000;
    localparam logic [15:0] ICT_CTRL2_RST = 16'h0000;
    localparam logic [4:0]  ICT_SRC_NONE  = 5'h00;
    localparam logic [2:0]  ICT_CLK_SYS   = 3'h7;
    localparam logic [2:0]  ICT_CLK_T1    = 3'h4;
    localparam logic [2:0]  ICT_CLK_T5    = 3'h3;
    localparam logic [2:0]  ICT_CLK_T4    = 3'h2;
    localparam logic [2:0]  ICT_CLK_T2    = 3'h1;
    localparam logic [1:0]  ICT_CPI_EVERY = 2'h0;
    localparam logic [1:0]  ICT_CPI_TWO   = 2'h1;
    localparam logic [15:0] ICT_CNT_MAX   = 16'hffff;

    // Capture modes
    localparam logic [2:0] ICT_MODE_OFF   = 3'h0;
    localparam logic [2:0] ICT_MODE_BOTH  = 3'h1;
    localparam logic [2:0] ICT_MODE_RISE  = 3'h3;
    localparam logic [2:0] ICT_MODE_R4    = 3'h4;
    localparam logic [2:0] ICT_MODE_R16   = 3'h5;
    localparam logic [2:0] ICT_MODE_DIS   = 3'h6;

    // Prescale counts
    localparam logic [3:0] ICT_PRE4_LAST  = 4'h3;
    localparam logic [3:0] ICT_PRE16_LAST = 4'hf;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ICT_FREE, ICT_SYNC, ICT_HWTRIG, ICT_SWTRIG} ict_run_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } ict_bus_s;

endpackage

// file: verification/ict_channel_bench.sv
// Purpose: Self-checking bench for a cascaded pair of capture channels
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   The cascade case waits for one full 16-bit wrap
`timescale 1ns/1ps
`default_nettype none
module ict_channel_bench;
    import ict_pkg::*;

    typedef struct {
        logic [2:0]  clk;
        logic [2:0]  mode;
        logic [1:0]  cpi;
        int          pulses;
        logic [2:0]  fill;
        logic [15:0] irqs;
        logic [15:0] diff;
    } ict_row_s;

    logic        clk_i;
    logic        rst_b_i;
    ict_bus_s    bus_odd;
    ict_bus_s    bus_even;
    logic [15:0] rdata_odd;
    logic [15:0] rdata_even;
    logic        pin;
    logic [31:0] src_evt;
    logic [31:0] src_en;
    logic [4:0]  tick;
    logic        en_odd;
    logic        en_even;
    logic        cy_odd;
    logic        cy_even;
    logic        irq_odd;
    logic        irq_even;
    logic [15:0] irq_cnt;
    logic [15:0] irq_base;
    logic [15:0] irq_ev;
    logic [15:0] v;
    logic [15:0] v0;
    int          err_total;
    int          n_checks;

    // Capture-mode table: clock, mode, per-irq, pulses, fill, irqs, ticks
    ict_row_s rows [6] = '{
        '{ICT_CLK_SYS, ICT_MODE_BOTH, ICT_CPI_EVERY, 1,  3'h2, 16'h0002, 16'h0020},
        '{ICT_CLK_T1,  ICT_MODE_RISE, ICT_CPI_TWO,   4,  3'h4, 16'h0002, 16'h0010},
        '{ICT_CLK_T2,  ICT_MODE_R4,   ICT_CPI_EVERY, 4,  3'h1, 16'h0001, 16'h0008},
        '{ICT_CLK_T4,  ICT_MODE_R16,  ICT_CPI_EVERY, 16, 3'h1, 16'h0001, 16'h0004},
        '{ICT_CLK_T5,  ICT_MODE_DIS,  ICT_CPI_EVERY, 3,  3'h0, 16'h0000, 16'h0002},
        '{ICT_CLK_SYS, ICT_MODE_OFF,  ICT_CPI_EVERY, 2,  3'h0, 16'h0000, 16'h0020}
    };

    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    ict_far_model i_ict_far_model (.clk_i(clk_i), .pin_o(pin), .src_evt_o(src_evt),
        .src_en_o(src_en), .tick_o(tick));
    ict_channel i_ict_channel_odd (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_odd),
        .rdata_o(rdata_odd), .pin_i(pin), .src_evt_i(src_evt), .src_en_i(src_en),
        .tmr_tick_i(tick), .casc_in_en_i(en_even), .casc_in_carry_i(cy_even),
        .casc_is_even_i(1'b0), .casc_out_en_o(en_odd), .casc_out_carry_o(cy_odd),
        .irq_o(irq_odd));
    ict_channel i_ict_channel_even (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_even),
        .rdata_o(rdata_even), .pin_i(pin), .src_evt_i(src_evt), .src_en_i(src_en),
        .tmr_tick_i(tick), .casc_in_en_i(en_odd), .casc_in_carry_i(cy_odd),
        .casc_is_even_i(1'b1), .casc_out_en_o(en_even), .casc_out_carry_o(cy_even),
        .irq_o(irq_even));

    // ------------------------------------------------------------------
    // Clock, interrupt counter, watchdog
    // ------------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Cleared by reset only; rows take a snapshot instead of clearing
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            irq_cnt <= 16'h0000;
            irq_ev  <= 16'h0000;
        end
        else
        begin
            if (irq_odd === 1'b1)
                irq_cnt <= irq_cnt + 16'h0001;
            if (irq_even === 1'b1)
                irq_ev <= irq_ev + 16'h0001;
        end
    end
    // The wrap alone takes about 66k cycles; everything else is small
    initial
    begin
        repeat (90000) @(posedge clk_i);
        err_total++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [15:0] c1(logic [2:0] ck, logic [1:0] cpi, logic [2:0] m);
        return {3'h0, ck, 3'h0, cpi, 2'h0, m};
    endfunction
    task automatic end_sim;
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input bit ch, input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        if (ch)
            bus_even <= '{1'b1, 1'b0, a, d};
        else
            bus_odd <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        bus_even <= '0;
        bus_odd <= '0;
    endtask
    task automatic rd(input bit ch, input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_i);
        if (ch)
            bus_even <= '{1'b0, 1'b1, a, 16'h0000};
        else
            bus_odd <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk_i);
        bus_even <= '0;
        bus_odd <= '0;
        #1;
        d = ch ? rdata_even : rdata_odd;
    endtask
    // Two counter reads exactly 32 cycles apart
    task automatic meas(output logic [15:0] d);
        logic [15:0] a;
        logic [15:0] b;
        rd(1'b0, ICT_ADDR_COUNTER, a);
        repeat (30) @(posedge clk_i);
        rd(1'b0, ICT_ADDR_COUNTER, b);
        d = b - a;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        err_total = 0;
        n_checks = 0;
        bus_odd = '0;
        bus_even = '0;
        rst_b_i = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(1'b0, ICT_ADDR_CTRL1, v);
        chk(v, ICT_CTRL1_RST);
        rd(1'b0, ICT_ADDR_CTRL2, v);
        chk(v, ICT_CTRL2_RST);
        rd(1'b0, 3'h7, v);
        chk(v, 16'h0000);
        foreach (rows[i])
        begin
            wr(1'b0, ICT_ADDR_CTRL1, c1(rows[i].clk, rows[i].cpi, ICT_MODE_OFF));
            repeat (4) rd(1'b0, ICT_ADDR_FIFO, v);
            meas(v);
            chk(v, rows[i].diff);
            wr(1'b0, ICT_ADDR_CTRL1, c1(rows[i].clk, rows[i].cpi, rows[i].mode));
            irq_base = irq_cnt;
            i_ict_far_model.pulses(rows[i].pulses);
            rd(1'b0, ICT_ADDR_STATUS, v);
            chk(v, {12'h000, rows[i].fill != 3'h0, rows[i].fill});
            chk(irq_cnt - irq_base, rows[i].irqs);
        end
        // Frozen time base: five captures into four entries
        @(posedge clk_i);
        i_ict_far_model.hold_r <= 5'h04;
        wr(1'b0, ICT_ADDR_CTRL1, c1(ICT_CLK_T2, ICT_CPI_EVERY, ICT_MODE_RISE) | 16'h0018);
        rd(1'b0, ICT_ADDR_CTRL1, v);
        chk(v, c1(ICT_CLK_T2, ICT_CPI_EVERY, ICT_MODE_RISE));
        rd(1'b0, ICT_ADDR_COUNTER, v0);
        i_ict_far_model.pulses(5);
        rd(1'b0, ICT_ADDR_STATUS, v);
        chk(v, 16'h001c);
        repeat (4)
        begin
            rd(1'b0, ICT_ADDR_FIFO, v);
            chk(v, v0);
        end
        rd(1'b0, ICT_ADDR_STATUS, v);
        chk(v, 16'h0000);
        rd(1'b0, ICT_ADDR_FIFO, v);
        chk(v, 16'h0000);
        @(posedge clk_i);
        i_ict_far_model.hold_r <= 5'h00;
        // Software trigger, hardware trigger, sync clear
        wr(1'b0, ICT_ADDR_CTRL1, c1(ICT_CLK_SYS, ICT_CPI_EVERY, ICT_MODE_OFF));
        wr(1'b0, ICT_ADDR_CTRL2, 16'h0080);
        meas(v);
        chk(v, 16'h0000);
        wr(1'b0, ICT_ADDR_CTRL2, 16'h00c0);
        meas(v);
        chk(v, 16'h0020);
        wr(1'b0, ICT_ADDR_CTRL2, 16'h0081);
        rd(1'b0, ICT_ADDR_COUNTER, v);
        chk(v, 16'h0000);
        i_ict_far_model.evt(1);
        rd(1'b0, ICT_ADDR_CTRL2, v);
        chk(v, 16'h00c1);
        meas(v);
        chk(v, 16'h0020);
        wr(1'b0, ICT_ADDR_CTRL2, 16'h0002);
        i_ict_far_model.src_en_o[2] <= 1'b1;
        repeat (40) @(posedge clk_i);
        i_ict_far_model.evt(2);
        rd(1'b0, ICT_ADDR_COUNTER, v);
        chk({15'h0000, v < 16'h0010}, 16'h0001);
        // Cascaded sync with its source off: both halves held clear
        wr(1'b1, ICT_ADDR_CTRL2, 16'h0103);
        wr(1'b0, ICT_ADDR_CTRL2, 16'h0103);
        wr(1'b1, ICT_ADDR_CTRL1, c1(ICT_CLK_SYS, ICT_CPI_EVERY, ICT_MODE_OFF));
        wr(1'b0, ICT_ADDR_CTRL1, c1(ICT_CLK_SYS, ICT_CPI_EVERY, ICT_MODE_OFF));
        rd(1'b0, ICT_ADDR_COUNTER, v);
        chk(v, 16'h0000);
        // Free cascade: even side first, then one wrap of the odd counter
        wr(1'b1, ICT_ADDR_CTRL2, 16'h0100);
        wr(1'b0, ICT_ADDR_CTRL2, 16'h0100);
        rd(1'b0, ICT_ADDR_COUNTER, v0);
        rd(1'b1, ICT_ADDR_COUNTER, v);
        repeat (int'(16'hffff - v0) + 16) @(posedge clk_i);
        rd(1'b1, ICT_ADDR_COUNTER, v0);
        chk(v0, v + 16'h0001);
        // One 32-bit capture: odd buffer low word, even buffer high word
        wr(1'b1, ICT_ADDR_CTRL1, c1(ICT_CLK_SYS, ICT_CPI_EVERY, ICT_MODE_RISE));
        wr(1'b0, ICT_ADDR_CTRL1, c1(ICT_CLK_SYS, ICT_CPI_EVERY, ICT_MODE_RISE));
        i_ict_far_model.pulses(1);
        rd(1'b0, ICT_ADDR_STATUS, v);
        chk(v, 16'h0009);
        rd(1'b0, ICT_ADDR_FIFO, v);
        chk({15'h0000, v < 16'h0100}, 16'h0001);
        rd(1'b1, ICT_ADDR_FIFO, v);
        chk(v, v0);
        chk(irq_ev, 16'h0001);
        end_sim();
    end
endmodule
`default_nettype wire

// file: verification/ict_far_model.sv
// Purpose: Far-side model: capture pin, sync/trigger sources, timer ticks
// Assumes: One clock; the bench calls the tasks below
// Notes:   Tick k pulses every 2**k cycles so count ratios stay exact
`timescale 1ns/1ps
`default_nettype none
module ict_far_model (
    input  wire logic   clk_i,
    output logic        pin_o,
    output logic [31:0] src_evt_o,
    output logic [31:0] src_en_o,
    output logic [4:0]  tick_o
);
    logic [4:0] free_r;
    logic [4:0] hold_r;

    // ------------------------------------------------------------------
    // Timer ticks
    // ------------------------------------------------------------------
    // A held tick freezes that time base, so captured values are known
    initial
    begin
        free_r = 5'h00;
        hold_r = 5'h00;
        pin_o = 1'b0;
        src_evt_o = 32'h0000_0000;
        src_en_o = 32'h0000_0000;
    end
    always @(posedge clk_i)
    begin
        free_r <= free_r + 5'h01;
    end
    always_comb
    begin
        for (int k = 0; k < 5; k++)
            tick_o[k] = ~hold_r[k] && ((free_r & ((5'h01 << k) - 5'h01)) == 5'h00);
    end

    // ------------------------------------------------------------------
    // Pin pulses and source events
    // ------------------------------------------------------------------
    // Long high and low phases so the pin synchroniser sees every edge
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
    endtask
    // Only timer and compare indices are sent as sync events
    task automatic evt(input int idx);
        @(posedge clk_i);
        src_evt_o[idx] <= 1'b1;
        @(posedge clk_i);
        src_evt_o <= 32'h0000_0000;
    endtask
endmodule
`default_nettype wire
